// File: current_reduction.v
`timescale 1ns/100ps
`default_nettype none
`include "stepper_motion_regs.vh"

module current_reduction #(
  parameter MS_CYCLES = 100000
) (
  // Clock and reset
  input  wire        clock,
  input  wire        srst,
  // Activity
  input  wire        motion,
  // Settings
  input  wire        stopEn,
  input  wire [14:0] stopMs,
  input  wire [11:0] idleS,
  input  wire [6:0]  idlePct,
  // Result
  output reg  [6:0]  currentPct,
  output wire        reduced
);

  // Cut to the counter width on purpose; the default fits in 20 bits
  localparam integer MS_LAST_I = MS_CYCLES - 1;
  localparam [19:0]  MS_LAST   = MS_LAST_I[19:0];

  reg  [19:0] tick;
  reg  [14:0] msCount;
  reg  [9:0]  msInSec;
  reg  [11:0] secCount;
  wire        msTick  = (tick == MS_LAST);
  wire [6:0]  idleLvl = `PCT_FULL - idlePct;
  wire        stopHit = stopEn && (msCount >= stopMs);
  wire        idleHit = (idleS != 12'h0) && (secCount >= idleS);
  reg  [6:0]  next_pct;

  // Standstill timers, restarted by any motion
  always @(posedge clock) begin
    if (srst || motion) begin
      tick     <= 20'h0;
      msCount  <= 15'h0;
      msInSec  <= 10'h0;
      secCount <= 12'h0;
    end else begin
      tick <= msTick ? 20'h0 : tick + 20'h00001;
      if (msTick && msCount != 15'h7fff)
        msCount <= msCount + 15'h0001;
      if (msTick) begin
        msInSec <= (msInSec == `MS_PER_S - 10'h001) ? 10'h0 :
                   msInSec + 10'h001;
        if (msInSec == `MS_PER_S - 10'h001 && secCount != 12'hfff)
          secCount <= secCount + 12'h001;
      end
    end
  end

  // Deepest active reduction wins
  always @* begin
    next_pct = `PCT_FULL;
    if (stopHit)
      next_pct = `PCT_FULL - `PCT_STOP_RED;
    if (idleHit && idleLvl < next_pct)
      next_pct = idleLvl;
  end

  always @(posedge clock) begin
    if (srst)
      currentPct <= `PCT_FULL;
    else if (motion)
      currentPct <= `PCT_FULL;
    else
      currentPct <= next_pct;
  end

  assign reduced = (currentPct != `PCT_FULL);

endmodule

`default_nettype wire

// File: stepper_far_side.sv
`timescale 1ns/100ps
`default_nettype none

module stepper_far_side (
  // Clock
  input  wire logic clock,
  // Indexer command
  input  wire logic go,
  input  wire logic dirCmd,
  // Power stage
  input  wire logic stepOut,
  input  wire logic dirOut,
  // Indexer pins
  output var logic  extStep,
  output var logic  extDir,
  // Counts
  output var int    sent,
  output var int    pos
);
  logic [1:0] phase;

  initial begin
    extStep = 1'b0;
    extDir = 1'b0;
    phase = 2'h0;
    sent = 0;
    pos = 0;
  end
  // Indexer: a rising edge every eight cycles keeps steps distinct
  always @(posedge clock) begin
    extDir <= dirCmd;
    if (go) begin
      phase <= phase + 2'h1;
      if (phase == 2'h3) begin
        extStep <= !extStep;
        if (!extStep) sent <= sent + 1;
      end
    end
  end
  // Rotor: one position per pulse, sign from direction level
  always @(posedge clock) begin
    if (stepOut === 1'b1) pos <= dirOut ? pos - 1 : pos + 1;
  end
endmodule
`default_nettype wire

// File: stepper_motion.v
`timescale 1ns/100ps
`default_nettype none
`include "stepper_motion_regs.vh"

module stepper_motion #(
  parameter MS_CYCLES = `MS_CYCLES,
  parameter CLK_HZ    = `CLK_HZ,
  parameter INTERP_LG = 4
) (
  // Clock and reset
  input  wire        clock,
  input  wire        srst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // External indexer
  input  wire        extStep,
  input  wire        extDir,
  // Discrete inputs
  input  wire        jogPos,
  input  wire        jogNeg,
  input  wire        jogSpeed,
  input  wire        stopIn,
  input  wire        travelLimitIn,
  input  wire        shutdownIn,
  input  wire        stallSense,
  // Power stage
  output reg         stepOut,
  output reg         dirOut,
  output reg  [6:0]  currentPct,
  output reg  [15:0] dampGainA,
  output reg  [15:0] dampGainB,
  // Status
  output reg         inMotion,
  output reg         stallDetected,
  output reg         irq
);

  localparam [39:0] STEP_DIV  = CLK_HZ * 40'd100;
  localparam [40:0] FAST_PROD = CLK_HZ * 41'd2;
  localparam [23:0] PER_MAX   = 24'hffffff;
  localparam [4:0]  INTERP_N  = 5'd1 << INTERP_LG;

  // Shadow settings written by software
  reg  [6:0]  ctrlSh;
  reg  [16:0] resSh;
  reg  [15:0] stopRateSh, jogAccelSh, jogLowSh, jogHighSh;
  reg  [14:0] stopMsSh;
  reg  [11:0] idleSSh;
  reg  [6:0]  idlePctSh;
  reg  [31:0] dampSh;
  reg  [15:0] gainSh;
  reg  [31:0] coefLow, coefMid, coefHigh;
  // Active settings used by the motion logic
  reg  [6:0]  ctrl;
  reg  [16:0] res;
  reg  [15:0] stopRate, jogAccel, jogLow, jogHigh;
  reg  [14:0] stopMs;
  reg  [11:0] idleS;
  reg  [6:0]  idlePct;
  reg  [31:0] damp;
  reg  [15:0] gain;
  // Interrupt registers
  reg  [4:0]  intStatus, intMask;

  wire apbWr  = psel && penable && pready && pwrite;
  wire commit = apbWr && paddr == `OFS_COMMIT;
  wire resOk  = (resSh >= `RES_MIN) && (resSh <= `RES_MAX) &&
                ((resSh % `RES_STEP) == 0);

  // Shadow writes; nothing reaches the motor until commit
  always @(posedge clock) begin
    if (srst) begin
      ctrlSh     <= `RST_CTRL;
      resSh      <= `RST_RESOLUTION;
      stopRateSh <= `RST_STOP_RATE;
      jogAccelSh <= `RST_JOG_ACCEL;
      jogLowSh   <= `RST_JOG_LOW;
      jogHighSh  <= `RST_JOG_HIGH;
      stopMsSh   <= `RST_STOP_MS;
      idleSSh    <= `RST_IDLE_S;
      idlePctSh  <= `RST_IDLE_PCT;
      dampSh     <= 32'h0;
      gainSh     <= 16'h0;
      coefLow    <= 32'h0;
      coefMid    <= {16'h0000, `RST_COEF_MID_A};
      coefHigh   <= 32'h0;
    end else if (apbWr) begin
      case (paddr)
        `OFS_CTRL:        ctrlSh     <= pwdata[6:0];
        `OFS_RESOLUTION:  resSh      <= pwdata[16:0];
        `OFS_STOP_RATE:   stopRateSh <= pwdata[15:0];
        `OFS_JOG_ACCEL:   jogAccelSh <= pwdata[15:0];
        `OFS_JOG_LOW:     jogLowSh   <= pwdata[15:0];
        `OFS_JOG_HIGH:    jogHighSh  <= pwdata[15:0];
        `OFS_STOP_MS:     stopMsSh   <= pwdata[14:0];
        `OFS_IDLE_S:      idleSSh    <= pwdata[11:0];
        `OFS_IDLE_PCT:    idlePctSh  <= pwdata[6:0];
        `OFS_DAMP:        dampSh     <= pwdata;
        `OFS_SMOOTH_GAIN: gainSh     <= pwdata[15:0];
        `OFS_COEF_LOW:    coefLow    <= pwdata;
        `OFS_COEF_MID:    coefMid    <= pwdata;
        `OFS_COEF_HIGH:   coefHigh   <= pwdata;
        default: ;
      endcase
    end
  end

  // Commit copies every setting but the coefficients at once, times and percent clamped; an illegal resolution rejects it all
  always @(posedge clock) begin
    if (srst) begin
      ctrl     <= `RST_CTRL;
      res      <= `RST_RESOLUTION;
      stopRate <= `RST_STOP_RATE;
      jogAccel <= `RST_JOG_ACCEL;
      jogLow   <= `RST_JOG_LOW;
      jogHigh  <= `RST_JOG_HIGH;
      stopMs   <= `RST_STOP_MS;
      idleS    <= `RST_IDLE_S;
      idlePct  <= `RST_IDLE_PCT;
      damp     <= 32'h0;
      gain     <= 16'h0;
    end else if (commit && resOk) begin
      ctrl     <= ctrlSh;
      res      <= resSh;
      stopRate <= stopRateSh;
      jogAccel <= jogAccelSh;
      jogLow   <= jogLowSh;
      jogHigh  <= jogHighSh;
      stopMs   <= (stopMsSh < `STOP_MS_MIN) ? `STOP_MS_MIN :
                  (stopMsSh > `STOP_MS_MAX) ? `STOP_MS_MAX : stopMsSh;
      idleS    <= (idleSSh > `IDLE_S_MAX) ? `IDLE_S_MAX : idleSSh;
      idlePct  <= (idlePctSh > `PCT_FULL) ? `PCT_FULL : idlePctSh;
      damp     <= dampSh;
      gain     <= gainSh;
    end
  end

  // Input qualification
  wire shutdown = ctrl[`CTRL_SHDN_HIGH] ? shutdownIn : ~shutdownIn;
  reg  limitPrev, limitLatched, limitDir, extPrev;
  wire limitRise = travelLimitIn && !limitPrev;
  wire limitFall = !travelLimitIn && limitPrev;
  wire extEdge   = extStep && !extPrev;

  // Jog direction only changes once the ramp has come to rest
  reg         jogDir;
  wire [15:0] vel, smoothVel;
  wire        jogReq   = jogPos ^ jogNeg;
  wire        reqDir   = jogNeg;
  wire        rampBusy = (vel != 16'h0) || (smoothVel != 16'h0);
  wire        stopping = stopIn || limitLatched || shutdown;
  wire        jogRun   = jogReq && !stopping && (reqDir == jogDir);
  wire [15:0] target   = !jogRun ? 16'h0 :
                         (jogSpeed ? jogHigh : jogLow);
  wire [15:0] rate     = stopping ? stopRate : jogAccel;
  wire [15:0] gainEff  = ctrl[`CTRL_INTERP] ? gain / 16'd10 : gain;
  wire        cmdDir   = rampBusy ? jogDir : extDir;

  always @(posedge clock) begin
    if (srst)
      jogDir <= 1'b0;
    else if (!rampBusy && jogReq)
      jogDir <= reqDir;
  end

  velocity_ramp #(
    .CLK_HZ   (CLK_HZ)
  ) u_ramp (
    .clock     (clock),
    .srst      (srst),
    .target    (target),
    .rate      (rate),
    .smoothEn  (ctrl[`CTRL_SMOOTH]),
    .gain      (gainEff),
    .vel       (vel),
    .smoothVel (smoothVel)
  );

  // Limit latches the travel direction until the switch releases
  always @(posedge clock) begin
    if (srst) begin
      limitPrev    <= 1'b0;
      limitLatched <= 1'b0;
      limitDir     <= 1'b0;
      extPrev      <= 1'b0;
    end else begin
      limitPrev <= travelLimitIn;
      extPrev   <= extStep;
      if (limitRise) begin
        limitLatched <= 1'b1;
        limitDir     <= cmdDir;
      end else if (limitFall) begin
        limitLatched <= 1'b0;
      end
    end
  end

  // Internal step generator from the smoothed velocity
  reg  [39:0] nco;
  wire [32:0] ncoInc = smoothVel * res;
  wire [39:0] ncoSum = nco + {7'h0, ncoInc};
  wire        ncoStep = (ncoSum >= STEP_DIV);

  always @(posedge clock) begin
    if (srst || !rampBusy)
      nco <= 40'h0;
    else
      nco <= ncoStep ? ncoSum - STEP_DIV : ncoSum;
  end

  // Coarse step period, saturating when the indexer goes quiet
  reg  [23:0] periodCnt, lastPeriod;
  reg  [4:0]  subLeft;
  reg  [23:0] subSpace, spaceCnt;
  reg         subDir;
  wire        subStep = (subLeft != 5'h0) && (spaceCnt == 24'h0);

  always @(posedge clock) begin
    if (srst) begin
      periodCnt  <= PER_MAX; // No step seen yet, so not moving
      lastPeriod <= PER_MAX;
    end else if (extEdge) begin
      periodCnt  <= 24'h0;
      lastPeriod <= periodCnt;
    end else if (periodCnt != PER_MAX) begin
      periodCnt <= periodCnt + 24'h000001;
    end
  end

  // Each coarse step is spread over INTERP_N evenly spaced microsteps
  always @(posedge clock) begin
    if (srst) begin
      subLeft  <= 5'h0;
      subSpace <= 24'h0;
      spaceCnt <= 24'h0;
      subDir   <= 1'b0;
    end else if (extEdge && ctrl[`CTRL_INTERP]) begin
      subLeft  <= INTERP_N;
      subSpace <= periodCnt >> INTERP_LG;
      spaceCnt <= 24'h0;
      subDir   <= extDir;
    end else if (subStep) begin
      subLeft  <= subLeft - 5'h01;
      spaceCnt <= subSpace;
    end else if (spaceCnt != 24'h0) begin
      spaceCnt <= spaceCnt - 24'h000001;
    end
  end

  // Step request, blocked by shutdown, by stop when the ramp is at rest, and by a limit in its latched direction
  wire extReq   = ctrl[`CTRL_INTERP] ? subStep : extEdge;
  wire reqStep  = rampBusy ? ncoStep : extReq;
  wire reqD     = rampBusy ? jogDir :
                  (ctrl[`CTRL_INTERP] ? subDir : extDir);
  wire blocked  = shutdown || (!rampBusy && stopIn) ||
                  (limitLatched && reqD == limitDir);
  reg  pending, pendDir;
  wire reduced;
  wire [6:0] pctNext;

  always @(posedge clock) begin
    if (srst) begin
      pending <= 1'b0;
      pendDir <= 1'b0;
    end else if (reqStep && !blocked) begin
      pending <= 1'b1;
      pendDir <= reqD;
    end else if (pending && !reduced) begin
      pending <= 1'b0;
    end
  end

  current_reduction #(
    .MS_CYCLES (MS_CYCLES)
  ) u_current (
    .clock      (clock),
    .srst       (srst),
    .motion     (pending || rampBusy),
    .stopEn     (ctrl[`CTRL_STOP_RED]),
    .stopMs     (stopMs),
    .idleS      (idleS),
    .idlePct    (idlePct),
    .currentPct (pctNext),
    .reduced    (reduced)
  );

  // Stall only counts above the minimum speed
  wire [40:0] perRes  = lastPeriod * res;
  wire [40:0] idleRes = periodCnt * res;
  wire        extFast = (perRes <= FAST_PROD) && (idleRes <= FAST_PROD);
  wire        fast    = (smoothVel >= `STALL_MIN_VEL) ||
                        (!rampBusy && extFast);
  wire        stallNow = ctrl[`CTRL_STALL] && stallSense && fast;
  reg         wasBusy;
  wire [4:0]  events;

  assign events[`INT_STOPPED] = wasBusy && !rampBusy && stopping;
  assign events[`INT_LIMIT]   = limitRise;
  assign events[`INT_STALL]   = stallNow && !stallDetected;
  assign events[`INT_REJECT]  = commit && !resOk;
  assign events[`INT_REDUCED] = !reduced && (pctNext != currentPct) &&
                                (pctNext != `PCT_FULL);

  // Output stage; step waits for full current
  always @(posedge clock) begin
    if (srst) begin
      stepOut       <= 1'b0;
      dirOut        <= 1'b0;
      currentPct    <= `PCT_FULL;
      dampGainA     <= 16'h0;
      dampGainB     <= 16'h0;
      inMotion      <= 1'b0;
      stallDetected <= 1'b0;
      wasBusy       <= 1'b0;
    end else begin
      stepOut       <= pending && !reduced;
      dirOut        <= (pending ? pendDir : cmdDir) ^
                       ctrl[`CTRL_DIR_SENSE];
      currentPct    <= shutdown ? 7'h00 : pctNext;
      dampGainA     <= ctrl[`CTRL_ANTI_RES] ? damp[15:0] : 16'h0;
      dampGainB     <= ctrl[`CTRL_ANTI_RES] ? damp[31:16] : 16'h0;
      inMotion      <= rampBusy || (periodCnt != PER_MAX);
      stallDetected <= stallNow;
      wasBusy       <= rampBusy;
    end
  end

  // Sticky events; a new event beats a same-cycle clear
  wire intWr = apbWr && paddr == `OFS_INT_STATUS;
  always @(posedge clock) begin
    if (srst) begin
      intStatus <= 5'h0;
      intMask   <= 5'h0;
      irq       <= 1'b0;
    end else begin
      intStatus <= (intStatus & ~(intWr ? pwdata[4:0] : 5'h0)) | events;
      if (apbWr && paddr == `OFS_INT_MASK)
        intMask <= pwdata[4:0];
      irq <= |(intStatus & intMask);
    end
  end

  // Read mux, registered in the setup cycle; zero wait states
  reg [31:0] next_rdata;
  reg        next_err;
  always @* begin
    next_rdata = 32'h0;
    next_err   = 1'b0;
    case (paddr)
      `OFS_CTRL:        next_rdata = {25'h0, ctrlSh};
      `OFS_RESOLUTION:  next_rdata = {15'h0, resSh};
      `OFS_STOP_RATE:   next_rdata = {16'h0, stopRateSh};
      `OFS_JOG_ACCEL:   next_rdata = {16'h0, jogAccelSh};
      `OFS_JOG_LOW:     next_rdata = {16'h0, jogLowSh};
      `OFS_JOG_HIGH:    next_rdata = {16'h0, jogHighSh};
      `OFS_STOP_MS:     next_rdata = {17'h0, stopMsSh};
      `OFS_IDLE_S:      next_rdata = {20'h0, idleSSh};
      `OFS_IDLE_PCT:    next_rdata = {25'h0, idlePctSh};
      `OFS_DAMP:        next_rdata = dampSh;
      `OFS_SMOOTH_GAIN: next_rdata = {16'h0, gainSh};
      `OFS_COEF_LOW:    next_rdata = coefLow;
      `OFS_COEF_MID:    next_rdata = coefMid;
      `OFS_COEF_HIGH:   next_rdata = coefHigh;
      `OFS_COMMIT:      next_rdata = 32'h0;
      `OFS_STATUS:      next_rdata = {17'h0, currentPct, 3'h0,
                                      stopping, limitLatched, shutdown,
                                      reduced, rampBusy};
      `OFS_INT_STATUS:  next_rdata = {27'h0, intStatus};
      `OFS_INT_MASK:    next_rdata = {27'h0, intMask};
      default:          next_err   = 1'b1;
    endcase
  end

  always @(posedge clock) begin
    if (srst) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= next_rdata;
      pslverr <= psel && !penable && next_err;
    end
  end

endmodule

`default_nettype wire

// File: stepper_motion_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "stepper_motion_regs.vh"

module stepper_motion_checker (
  // Clock and reset
  input wire logic       clock,
  input wire logic       srst,
  // Bus
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  // Drive
  input wire logic       stepOut,
  input wire logic [6:0] currentPct,
  input wire logic       inMotion,
  input wire logic       stallDetected,
  input wire logic       irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // Bus answers last a single cycle
  a_pready_once: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // Past the map the access is refused
  a_unmapped_err: assert property (psel && !penable &&
    paddr > `OFS_INT_MASK |=> pready && pslverr)
    else $error("unmapped access not refused");
  // Power stage pulses and levels
  a_step_single: assert property (stepOut |=> !stepOut)
    else $error("step pulse too long");
  a_full_on_step: assert property (stepOut |-> currentPct == `PCT_FULL)
    else $error("step at reduced current");
  a_pct_range: assert property (currentPct <= `PCT_FULL)
    else $error("current above full");
  a_stall_moving: assert property (stallDetected |-> inMotion)
    else $error("stall at standstill");
  // First edge after reset still shows reset values
  a_reset_state: assert property ($fell(srst) |->
    currentPct == `PCT_FULL && !stepOut && !irq && !pready)
    else $error("outputs not at reset values");

  c_step: cover property (stepOut);
  c_irq: cover property ($rose(irq));
  c_reduced: cover property (currentPct == 7'h4b);
endmodule

bind stepper_motion stepper_motion_checker i_chk (
  .clock(clock), .srst(srst), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .stepOut(stepOut),
  .currentPct(currentPct), .inMotion(inMotion),
  .stallDetected(stallDetected), .irq(irq));
`default_nettype wire

// File: stepper_motion_regs.vh
`ifndef STEPPER_MOTION_REGS_VH
`define STEPPER_MOTION_REGS_VH

// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_RESOLUTION  8'h04
`define OFS_STOP_RATE   8'h08
`define OFS_JOG_ACCEL   8'h0c
`define OFS_JOG_LOW     8'h10
`define OFS_JOG_HIGH    8'h14
`define OFS_STOP_MS     8'h18
`define OFS_IDLE_S      8'h1c
`define OFS_IDLE_PCT    8'h20
`define OFS_DAMP        8'h24
`define OFS_SMOOTH_GAIN 8'h28
`define OFS_COEF_LOW    8'h2c
`define OFS_COEF_MID    8'h30
`define OFS_COEF_HIGH   8'h34
`define OFS_COMMIT      8'h38
`define OFS_STATUS      8'h3c
`define OFS_INT_STATUS  8'h40
`define OFS_INT_MASK    8'h44

// Control bit positions
`define CTRL_DIR_SENSE  0
`define CTRL_SHDN_HIGH  1
`define CTRL_STOP_RED   2
`define CTRL_ANTI_RES   3
`define CTRL_SMOOTH     4
`define CTRL_INTERP     5
`define CTRL_STALL      6
`define CTRL_WIDTH      7

// Interrupt bit positions
`define INT_STOPPED     0
`define INT_LIMIT       1
`define INT_STALL       2
`define INT_REJECT      3
`define INT_REDUCED     4
`define INT_WIDTH       5

// Reset values (speeds in hundredths of a unit)
`define RST_CTRL        7'h00
`define RST_RESOLUTION  17'h061a8
`define RST_STOP_RATE   16'h07d0
`define RST_JOG_ACCEL   16'h07d0
`define RST_JOG_LOW     16'h0032
`define RST_JOG_HIGH    16'h00c8
`define RST_STOP_MS     15'h0064
`define RST_IDLE_S      12'h000
`define RST_IDLE_PCT    7'h00
`define RST_COEF_MID_A  16'h1f40

// Limits
`define RES_STEP        200
`define RES_MIN         17'h000c8
`define RES_MAX         17'h186a0
`define STOP_MS_MIN     15'h0006
`define STOP_MS_MAX     15'h4cc8
`define IDLE_S_MAX      12'he10
`define PCT_FULL        7'h64
`define PCT_STOP_RED    7'h19
`define STALL_MIN_VEL   16'h0032

// Timing
`define CLK_PERIOD_NS   10
`define MS_NS           1000000
`define MS_CYCLES       (`MS_NS / `CLK_PERIOD_NS)
`define CLK_HZ          (1000000000 / `CLK_PERIOD_NS)
`define MS_PER_S        10'h3e8

`endif

// File: tb_stepper_drive_motion_settings.sv
`timescale 1ns/100ps
`default_nettype none
`include "stepper_motion_regs.vh"

module tb_stepper_drive_motion_settings;
  logic        clock, srst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        go, dirCmd, extStep, extDir, stepOut, dirOut, irq;
  logic        jogPos, jogNeg, jogSpeed, stopIn, travelLimitIn;
  logic        shutdownIn, stallSense, inMotion, stallDetected;
  logic [6:0]  currentPct;
  logic [15:0] dampGainA, dampGainB;
  int          errors, checked, cyc, sent, pos, p0, s0, nLow, nHigh;

  // Short ms and slow clock figure keep timers and ramps brief
  stepper_motion #(.MS_CYCLES(10), .CLK_HZ(100000)) i_dut (
    .clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .extStep(extStep),
    .extDir(extDir), .jogPos(jogPos), .jogNeg(jogNeg),
    .jogSpeed(jogSpeed), .stopIn(stopIn), .travelLimitIn(travelLimitIn),
    .shutdownIn(shutdownIn), .stallSense(stallSense), .stepOut(stepOut),
    .dirOut(dirOut), .currentPct(currentPct), .dampGainA(dampGainA),
    .dampGainB(dampGainB), .inMotion(inMotion),
    .stallDetected(stallDetected), .irq(irq));
  stepper_far_side i_far (.clock(clock), .go(go), .dirCmd(dirCmd),
    .stepOut(stepOut), .dirOut(dirOut), .extStep(extStep),
    .extDir(extDir), .sent(sent), .pos(pos));

  initial clock = 1'b0;
  always #5 clock = !clock;
  // Hang guard well past the longest run
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors = errors + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // One transfer; waits for pready, never a fixed count
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    chk({pready, pslverr}, {1'b1, a > `OFS_INT_MASK});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic waitPct(input logic [6:0] e, input int n);
    while (currentPct !== e && n > 0) begin
      @(posedge clock);
      n--;
    end
    chk(currentPct, e);
  endtask
  task automatic run(input int n);
    p0 = pos;
    s0 = sent;
    go <= 1'b1;
    tick(n);
    go <= 1'b0;
    tick(12);
  endtask
  task automatic cnt(output int c);
    c = 0;
    repeat (400) begin
      @(posedge clock);
      if (stepOut === 1'b1) c++;
    end
  endtask

  task automatic t_defaults();
    rc(`OFS_RESOLUTION, 32'h61a8);
    rc(`OFS_JOG_ACCEL, 32'h7d0);
    rc(`OFS_JOG_LOW, 32'h32);
    rc(`OFS_JOG_HIGH, 32'hc8);
    rc(8'h48, 32'h0);
    rc(`OFS_COEF_MID, 32'h1f40);
    wr(`OFS_COEF_LOW, 32'h20001);
    wr(`OFS_COEF_MID, 32'h41f40);
    wr(`OFS_COEF_HIGH, 32'h60005);
    rc(`OFS_COEF_LOW, 32'h20001);
    chk(inMotion, 1'b0);
  endtask
  task automatic t_shutdown();
    wr(`OFS_DAMP, 32'h20001);
    wr(`OFS_CTRL, 32'ha);
    chk({dampGainB, dampGainA}, 32'h0);
    wr(`OFS_COMMIT, 32'h1);
    waitPct(7'h0, 5);
    chk({dampGainB, dampGainA}, 32'h20001);
    shutdownIn <= 1'b0;
    waitPct(7'h64, 5);
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_COMMIT, 32'h1);
    waitPct(7'h0, 5);
    shutdownIn <= 1'b1;
    waitPct(7'h64, 5);
  endtask
  // Rejected commits raise the interrupt, masked then unmasked
  task automatic t_reject();
    wr(`OFS_RESOLUTION, 32'hc9);
    wr(`OFS_COMMIT, 32'h1);
    rc(`OFS_INT_STATUS, 32'h8);
    chk(irq, 1'b0);
    wr(`OFS_INT_MASK, 32'h8);
    tick(3);
    chk(irq, 1'b1);
    wr(`OFS_INT_STATUS, 32'h8);
    tick(3);
    chk(irq, 1'b0);
    wr(`OFS_RESOLUTION, 32'h186a0);
    wr(`OFS_COMMIT, 32'h1);
    rc(`OFS_INT_STATUS, 32'h0);
    wr(`OFS_RESOLUTION, 32'h186c8);
    wr(`OFS_COMMIT, 32'h1);
    rc(`OFS_INT_STATUS, 32'h8);
    wr(`OFS_INT_STATUS, 32'h8);
    wr(`OFS_RESOLUTION, 32'h61a8);
    wr(`OFS_COMMIT, 32'h1);
  endtask
  task automatic t_reduce();
    wr(`OFS_STOP_MS, 32'h6);
    wr(`OFS_IDLE_S, 32'h1);
    wr(`OFS_IDLE_PCT, 32'h28);
    wr(`OFS_CTRL, 32'h4);
    wr(`OFS_COMMIT, 32'h1);
    waitPct(7'h4b, 80);
    waitPct(7'h3c, 10500);
    run(5);
    chk(pos - p0, sent - s0);
    chk(currentPct, 7'h64);
  endtask
  task automatic t_dir();
    run(64);
    chk(pos - p0, sent - s0);
    chk(inMotion, 1'b1);
    wr(`OFS_CTRL, 32'h1);
    run(64);
    chk(pos - p0, sent - s0);
    wr(`OFS_COMMIT, 32'h1);
    run(64);
    chk(p0 - pos, sent - s0);
    stopIn <= 1'b1;
    run(64);
    chk(pos - p0, 32'h0);
    stopIn <= 1'b0;
  endtask
  // One coarse step is spread into sixteen microsteps
  task automatic t_interp();
    wr(`OFS_CTRL, 32'h20);
    wr(`OFS_COMMIT, 32'h1);
    run(8);
    tick(30);
    chk(sent - s0, 32'h1);
    chk(pos - p0, 32'h10);
  endtask
  // Low then high jog speed, smoothed, then a stop ramps down
  task automatic t_jog();
    wr(`OFS_CTRL, 32'h70);
    wr(`OFS_SMOOTH_GAIN, 32'hffff);
    wr(`OFS_COMMIT, 32'h1);
    wr(`OFS_INT_STATUS, 32'h1f);
    jogPos <= 1'b1;
    tick(3000);
    cnt(nLow);
    chk(nLow >= 45 && nLow <= 55, 1'b1);
    jogSpeed <= 1'b1;
    stallSense <= 1'b1;
    tick(8000);
    cnt(nHigh);
    chk(nHigh >= 190, 1'b1);
    chk(stallDetected, 1'b1);
    stopIn <= 1'b1;
    cnt(nLow);
    chk(nLow > 100, 1'b1);
    tick(11000);
    cnt(nLow);
    chk(nLow, 32'h0);
    apb(1'b0, `OFS_INT_STATUS, 32'h0);
    chk(q & 32'h5, 32'h5);
  endtask

  initial begin
    {srst, psel, penable, pwrite, go, dirCmd} = 6'h20;
    {jogPos, jogNeg, jogSpeed, stopIn, travelLimitIn} = 5'h0;
    shutdownIn = 1'b1;
    stallSense = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    tick(12);
    srst <= 1'b0;
    t_defaults();
    t_shutdown();
    t_reject();
    t_reduce();
    t_dir();
    t_interp();
    t_jog();
    end_sim();
  end
endmodule
`default_nettype wire

// File: velocity_ramp.v
`timescale 1ns/100ps
`default_nettype none

module velocity_ramp #(
  parameter CLK_HZ = 100000000
) (
  // Clock and reset
  input  wire        clock,
  input  wire        srst,
  // Profile request
  input  wire [15:0] target,
  input  wire [15:0] rate,
  input  wire        smoothEn,
  input  wire [15:0] gain,
  // Profile output
  output reg  [15:0] vel,
  output reg  [15:0] smoothVel
);

  localparam [31:0] HZ = CLK_HZ;

  reg  [31:0] frac;
  wire [31:0] fracSum = frac + {16'h0000, rate};
  wire [16:0] diff    = {1'b0, vel} - {1'b0, smoothVel};
  wire [15:0] mag     = diff[16] ? (~diff[15:0] + 16'h0001) : diff[15:0];
  wire [31:0] prod    = mag * gain;
  wire [15:0] delta   = (prod[31:16] == 16'h0000) ? 16'h0001 : prod[31:16];

  // Linear ramp: one hundredth per CLK_HZ of accumulated rate
  always @(posedge clock) begin
    if (srst) begin
      frac <= 32'h0;
      vel  <= 16'h0;
    end else if (vel == target) begin
      frac <= 32'h0;
    end else if (fracSum >= HZ) begin
      frac <= fracSum - HZ;
      vel  <= (vel < target) ? vel + 16'h0001 : vel - 16'h0001;
    end else begin
      frac <= fracSum;
    end
  end

  // First-order filter on the ramp rounds off jerk
  always @(posedge clock) begin
    if (srst) begin
      smoothVel <= 16'h0;
    end else if (!smoothEn || gain == 16'h0) begin
      smoothVel <= vel;
    end else if (mag != 16'h0) begin
      if (diff[16])
        smoothVel <= (delta > mag) ? vel : smoothVel - delta;
      else
        smoothVel <= (delta > mag) ? vel : smoothVel + delta;
    end
  end

endmodule

`default_nettype wire
